/* include/core_agen_defs.vh */
/*
 * constants of the core address generation block: register indices,
 * reset values, field positions, event bits.
 * assumes a 100 MHz core clock and an apb master with 32-bit data.
 */
`ifndef CORE_AGEN_DEFS_VH
`define CORE_AGEN_DEFS_VH
// register indices; byte address is four times the index
`define IX_WREG13 7'h1a
`define IX_FRAME 7'h1c
`define IX_STACK 7'h1e
`define IX_SLIMIT 7'h20
`define IX_ACC_AL 7'h22
`define IX_ACC_AH 7'h24
`define IX_ACC_AU 7'h26
`define IX_ACC_BL 7'h28
`define IX_ACC_BH 7'h2a
`define IX_ACC_BU 7'h2c
`define IX_PC_LO 7'h2e
`define IX_PC_HI 7'h30
`define IX_TPAGE 7'h32
`define IX_CPAGE 7'h34
`define IX_RPT_CNT 7'h36
`define IX_DO_CNT 7'h38
`define IX_LST_LO 7'h3a
`define IX_LST_HI 7'h3c
`define IX_LEND_LO 7'h3e
`define IX_LEND_HI 7'h40
`define IX_STATUS 7'h42
`define IX_CONTROL 7'h44
`define IX_CIRC_CTRL 7'h46
`define IX_XC_START 7'h48
`define IX_XC_END 7'h4a
`define IX_YC_START 7'h4c
`define IX_YC_END 7'h4e
`define IX_BITREV 7'h50
`define IX_IRQ_DIS 7'h52
`define IX_EVT_STAT 7'h54
`define IX_EVT_MASK 7'h56
// reset values
`define RST_ZERO 16'h0000
`define RST_STACK 16'h0800
`define RST_CONTROL 16'h0020
// implemented-bit masks of mixed registers
`define MSK_ACC_U 16'h00ff
`define MSK_PC_HI 16'h007f
`define MSK_PAGE 16'h00ff
`define MSK_LOOP_HI 16'h007f
`define MSK_LOOP_LO 16'hfffe
`define MSK_CONTROL 16'h1fff
`define MSK_IRQ_DIS 16'h3fff
`define MSK_SLIMIT 16'hfffe
`define BIT0_ONE 16'h0001
// field positions
`define ACC_SIGN 7
`define CC_X_EN 15
`define CC_Y_EN 14
`define BR_EN 15
`define BR_MOD_HI 14
// stack
`define STACK_FLOOR 16'h0800
`define STACK_STEP 16'h0002
// addressing modes
`define MODE_LINEAR 2'h0
`define MODE_CIRC 2'h1
`define MODE_BITREV 2'h2
// event bits
`define EV_STACK 0
`define EV_REFUSE 1
`define EV_WRAP 2
`define EV_W 3
`endif

/* logic/core_address_generation.v */
/*
 * core register file and two address generators behind an apb slave.
 * assumes the datapath issues one generator request per cycle per side
 * and that push and pop are never asserted together.
 */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "core_agen_defs.vh"
module core_address_generation #(
    parameter AW = 16
) (
    input wire mclk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire pri_req,
    input wire [AW-1:0] pri_ptr,
    input wire [AW-1:0] pri_step,
    input wire [1:0] pri_mode,
    input wire pri_prog,
    output reg pri_valid,
    output reg [AW-1:0] pri_addr,
    output reg [AW-1:0] pri_next,
    input wire sec_req,
    input wire [AW-1:0] sec_ptr,
    input wire [AW-1:0] sec_step,
    input wire [1:0] sec_mode,
    input wire sec_write,
    input wire sec_byte,
    output reg sec_valid,
    output reg [AW-1:0] sec_addr,
    output reg [AW-1:0] sec_next,
    input wire stack_push,
    input wire stack_pop,
    output reg stack_error,
    output reg irq_disabled,
    output reg irq
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;
    localparam [15:0] CTRL_RST = `RST_CONTROL;

    reg [1:0] state;
    reg [15:0] wreg13;
    reg [15:0] frame_ptr;
    reg [15:0] stack_ptr;
    reg [15:0] stack_limit;
    reg [15:0] acc_al;
    reg [15:0] acc_ah;
    reg [15:0] acc_bl;
    reg [15:0] acc_bh;
    reg [7:0] acc_au;
    reg [7:0] acc_bu;
    reg [15:0] pc_lo;
    reg [6:0] pc_hi;
    reg [7:0] tpage;
    reg [7:0] cpage;
    reg [15:0] core_status;
    reg [12:0] core_control;
    reg [15:0] circ_ctrl;
    reg [13:0] irq_dis_cnt;
    reg [`EV_W-1:0] evt_stat;
    reg [`EV_W-1:0] evt_mask;
    // uninitialized group: deliberately no reset
    reg [15:0] rpt_cnt;
    reg [15:0] do_cnt;
    reg [15:0] lst_lo;
    reg [15:0] lend_lo;
    reg [6:0] lst_hi;
    reg [6:0] lend_hi;
    reg [15:1] xc_start;
    reg [15:1] xc_end;
    reg [15:1] yc_start;
    reg [15:1] yc_end;
    reg [15:0] bitrev_ctrl;

    wire [6:0] idx = paddr[8:2];
    wire access = psel & penable & pready;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire [15:0] wd = pwdata[15:0];

    // circular step: length from the bounds, never stored
    function [16:0] circ_step;
        input [15:0] p;
        input [15:0] s;
        input [15:0] lo;
        input [15:0] hi;
        reg [15:0] n, len;
        begin
            n = p + s;
            len = hi - lo + `BIT0_ONE;
            if (!s[15] && n > hi) begin
                circ_step = {1'b1, n - len};
            end else if (s[15] && n < lo) begin
                circ_step = {1'b1, n + len};
            end else begin
                circ_step = {1'b0, n};
            end
        end
    endfunction

    wire [15:0] xlo = {xc_start, 1'b0};
    wire [15:0] xhi = {xc_end, 1'b1};
    wire [15:0] ylo = {yc_start, 1'b0};
    wire [15:0] yhi = {yc_end, 1'b1};
    wire [15:0] br_mod = {1'b0, bitrev_ctrl[`BR_MOD_HI:0]};

    // reverse-carry add built per bit: reverse, add, reverse back
    wire [15:0] ptr_rev;
    wire [15:0] mod_rev;
    wire [15:0] brev_next;
    wire [15:0] sum_rev = ptr_rev + mod_rev;
    genvar gb;
    generate
        for (gb = 0; gb < 16; gb = gb + 1) begin : g_rev
            assign ptr_rev[gb] = pri_ptr[15-gb];
            assign mod_rev[gb] = br_mod[15-gb];
            assign brev_next[gb] = sum_rev[15-gb];
        end
    endgenerate

    // primary generator, data or program space
    reg [15:0] next_pri;
    reg pri_wrap;
    reg [16:0] pc_res;
    always @* begin
        pc_res = 17'h00000;
        pri_wrap = 1'b0;
        next_pri = pri_ptr + pri_step;
        if (pri_mode == `MODE_CIRC && circ_ctrl[`CC_X_EN]) begin
            pc_res = circ_step(pri_ptr, pri_step, xlo, xhi);
            next_pri = pc_res[15:0];
            pri_wrap = pc_res[16];
        end else if (pri_mode == `MODE_BITREV && !pri_prog
                     && bitrev_ctrl[`BR_EN]) begin
            // reverse-carry add; program space falls back to linear
            next_pri = brev_next;
        end
    end

    // secondary generator, word reads of dual-operand instructions only
    reg [15:0] next_sec;
    reg sec_wrap;
    reg [16:0] sc_res;
    wire sec_ok = sec_req & ~sec_write & ~sec_byte;
    always @* begin
        sc_res = 17'h00000;
        sec_wrap = 1'b0;
        next_sec = sec_ptr + sec_step;
        if (sec_mode == `MODE_CIRC && circ_ctrl[`CC_Y_EN]) begin
            sc_res = circ_step(sec_ptr, sec_step, ylo, yhi);
            next_sec = sc_res[15:0];
            sec_wrap = sc_res[16];
        end
    end

    // both generators answer in the same cycle, independently
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pri_valid <= 1'b0;
            pri_addr <= `RST_ZERO;
            pri_next <= `RST_ZERO;
            sec_valid <= 1'b0;
            sec_addr <= `RST_ZERO;
            sec_next <= `RST_ZERO;
        end else begin
            pri_valid <= pri_req;
            pri_addr <= pri_req ? pri_ptr : pri_addr;
            pri_next <= pri_req ? next_pri : pri_next;
            sec_valid <= sec_ok;
            sec_addr <= sec_ok ? {sec_ptr[15:1], 1'b0} : sec_addr;
            sec_next <= sec_ok ? next_sec : sec_next;
        end
    end

    // stack checks on push and pop effective addresses
    wire [15:0] sp_inc = stack_ptr + `STACK_STEP;
    wire [15:0] sp_dec = stack_ptr - `STACK_STEP;
    wire over = stack_push & (stack_ptr > stack_limit);
    wire under = (stack_push & (stack_ptr < `STACK_FLOOR))
               | (stack_pop & (sp_dec < `STACK_FLOOR));
    wire stack_ev = over | under;

    wire [`EV_W-1:0] ev;
    assign ev[`EV_STACK] = stack_ev;
    assign ev[`EV_REFUSE] = sec_req & ~sec_ok;
    assign ev[`EV_WRAP] = (pri_req & pri_wrap) | (sec_ok & sec_wrap);

    // apb handshake: one wait state, answer registered
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            pready <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (psel & penable) begin
                        state <= ST_DONE;
                        pready <= 1'b1;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    pready <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // read mux; unimplemented bits read zero, except accumulator upper bits 15:8 (copies of bit 7) and end-bound bit 0 (one)
    reg [15:0] rdv;
    reg hit;
    always @* begin
        hit = 1'b1;
        case (idx)
            `IX_WREG13: rdv = wreg13;
            `IX_FRAME: rdv = frame_ptr;
            `IX_STACK: rdv = stack_ptr;
            `IX_SLIMIT: rdv = stack_limit & `MSK_SLIMIT;
            `IX_ACC_AL: rdv = acc_al;
            `IX_ACC_AH: rdv = acc_ah;
            `IX_ACC_AU: rdv = {{8{acc_au[`ACC_SIGN]}}, acc_au};
            `IX_ACC_BL: rdv = acc_bl;
            `IX_ACC_BH: rdv = acc_bh;
            `IX_ACC_BU: rdv = {{8{acc_bu[`ACC_SIGN]}}, acc_bu};
            `IX_PC_LO: rdv = pc_lo;
            `IX_PC_HI: rdv = {9'h000, pc_hi};
            `IX_TPAGE: rdv = {8'h00, tpage};
            `IX_CPAGE: rdv = {8'h00, cpage};
            `IX_RPT_CNT: rdv = rpt_cnt;
            `IX_DO_CNT: rdv = do_cnt;
            `IX_LST_LO: rdv = lst_lo & `MSK_LOOP_LO;
            `IX_LST_HI: rdv = {9'h000, lst_hi};
            `IX_LEND_LO: rdv = lend_lo & `MSK_LOOP_LO;
            `IX_LEND_HI: rdv = {9'h000, lend_hi};
            `IX_STATUS: rdv = core_status;
            `IX_CONTROL: rdv = {3'h0, core_control};
            `IX_CIRC_CTRL: rdv = circ_ctrl;
            `IX_XC_START: rdv = xlo;
            `IX_XC_END: rdv = xhi;
            `IX_YC_START: rdv = ylo;
            `IX_YC_END: rdv = yhi;
            `IX_BITREV: rdv = bitrev_ctrl;
            `IX_IRQ_DIS: rdv = {2'h0, irq_dis_cnt};
            `IX_EVT_STAT: rdv = {13'h0000, evt_stat};
            `IX_EVT_MASK: rdv = {13'h0000, evt_mask};
            default: begin
                rdv = `RST_ZERO;
                hit = 1'b0;
            end
        endcase
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (state == ST_IDLE && psel && penable) begin
            prdata <= pwrite ? 32'h00000000 : {16'h0000, rdv};
            pslverr <= ~hit | (paddr[11:9] != 3'h0) | (paddr[1:0] != 2'h0);
        end
    end

    wire wok = wr & ~pslverr;

    // reset-defined registers
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wreg13 <= `RST_ZERO;
            frame_ptr <= `RST_ZERO;
            stack_ptr <= `RST_STACK;
            stack_limit <= `RST_ZERO;
            acc_al <= `RST_ZERO;
            acc_ah <= `RST_ZERO;
            acc_au <= 8'h00;
            acc_bl <= `RST_ZERO;
            acc_bh <= `RST_ZERO;
            acc_bu <= 8'h00;
            pc_lo <= `RST_ZERO;
            pc_hi <= 7'h00;
            tpage <= 8'h00;
            cpage <= 8'h00;
            core_status <= `RST_ZERO;
            core_control <= CTRL_RST[12:0];
            circ_ctrl <= `RST_ZERO;
            irq_dis_cnt <= 14'h0000;
            evt_mask <= 3'h0;
        end else begin
            if (stack_push) begin
                stack_ptr <= sp_inc;
            end else if (stack_pop) begin
                stack_ptr <= sp_dec;
            end
            // disable counter runs down one per cycle
            if (irq_dis_cnt != 14'h0000) begin
                irq_dis_cnt <= irq_dis_cnt - 14'h0001;
            end
            if (wok) begin
                case (idx)
                    `IX_WREG13: wreg13 <= wd;
                    `IX_FRAME: frame_ptr <= wd;
                    `IX_STACK: stack_ptr <= wd;
                    `IX_SLIMIT: stack_limit <= wd & `MSK_SLIMIT;
                    `IX_ACC_AL: acc_al <= wd;
                    `IX_ACC_AH: acc_ah <= wd;
                    `IX_ACC_AU: acc_au <= wd[7:0];
                    `IX_ACC_BL: acc_bl <= wd;
                    `IX_ACC_BH: acc_bh <= wd;
                    `IX_ACC_BU: acc_bu <= wd[7:0];
                    `IX_PC_LO: pc_lo <= wd;
                    `IX_PC_HI: pc_hi <= wd[6:0];
                    `IX_TPAGE: tpage <= wd[7:0];
                    `IX_CPAGE: cpage <= wd[7:0];
                    `IX_STATUS: core_status <= wd;
                    `IX_CONTROL: core_control <= wd[12:0];
                    `IX_CIRC_CTRL: circ_ctrl <= wd;
                    `IX_IRQ_DIS: irq_dis_cnt <= wd[13:0];
                    `IX_EVT_MASK: evt_mask <= wd[`EV_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // no reset here: contents are undefined until written
    always @(posedge mclk) begin
        if (wok) begin
            case (idx)
                `IX_RPT_CNT: rpt_cnt <= wd;
                `IX_DO_CNT: do_cnt <= wd;
                `IX_LST_LO: lst_lo <= wd & `MSK_LOOP_LO;
                `IX_LST_HI: lst_hi <= wd[6:0];
                `IX_LEND_LO: lend_lo <= wd & `MSK_LOOP_LO;
                `IX_LEND_HI: lend_hi <= wd[6:0];
                `IX_XC_START: xc_start <= wd[15:1];
                `IX_XC_END: xc_end <= wd[15:1];
                `IX_YC_START: yc_start <= wd[15:1];
                `IX_YC_END: yc_end <= wd[15:1];
                `IX_BITREV: bitrev_ctrl <= wd;
                default: begin
                end
            endcase
        end
    end

    // events: set beats the read-clear
    wire clr = rd & ~pslverr & (idx == `IX_EVT_STAT);
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            evt_stat <= 3'h0;
            stack_error <= 1'b0;
            irq <= 1'b0;
            irq_disabled <= 1'b0;
        end else begin
            // clear only what the read reported; a set in the answer cycle survives
            evt_stat <= (clr ? evt_stat & ~prdata[`EV_W-1:0] : evt_stat) | ev;
            stack_error <= stack_ev;
            irq <= |(evt_stat & evt_mask);
            irq_disabled <= irq_dis_cnt != 14'h0000;
        end
    end
endmodule

/* tb/core_agen_checker.sv */
/* port checker for core_address_generation.
   assumes one clock domain and the active-low async reset. */
`timescale 1ns/1ps
`include "core_agen_defs.vh"
module core_agen_checker #(
    parameter AW = 16
) (
    input wire mclk,
    input wire reset_n,
    input wire pready,
    input wire [31:0] prdata,
    input wire pri_req,
    input wire [AW-1:0] pri_ptr,
    input wire [AW-1:0] pri_step,
    input wire [1:0] pri_mode,
    input wire pri_prog,
    input wire pri_valid,
    input wire [AW-1:0] pri_addr,
    input wire [AW-1:0] pri_next,
    input wire sec_req,
    input wire [AW-1:0] sec_ptr,
    input wire sec_write,
    input wire sec_byte,
    input wire sec_valid,
    input wire [AW-1:0] sec_addr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_pri_answers: assert property (pri_req |=> pri_valid)
        else $error("primary answer missing");
    a_pri_addr: assert property (pri_req |=> pri_addr == $past(pri_ptr))
        else $error("primary address not the pointer");
    a_both_cycle: assert property (pri_req && sec_req && !sec_write && !sec_byte
        |=> pri_valid && sec_valid)
        else $error("generators not independent");
    a_pri_linear: assert property (pri_req && pri_mode == `MODE_LINEAR
        |=> pri_next == $past(pri_ptr) + $past(pri_step))
        else $error("linear step wrong");
    a_prog_no_brev: assert property (pri_req && pri_prog && pri_mode == `MODE_BITREV
        |=> pri_next == $past(pri_ptr) + $past(pri_step))
        else $error("program space got bit reversal");
    a_sec_refuse: assert property (sec_req && (sec_write || sec_byte) |=> !sec_valid)
        else $error("secondary took a write or byte");
    a_sec_word: assert property (sec_req && !sec_write && !sec_byte
        |=> sec_valid && !sec_addr[0] && (sec_addr >> 1) == ($past(sec_ptr) >> 1))
        else $error("secondary address not a word");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("unused read bits not zero");
endmodule
bind core_address_generation core_agen_checker #(.AW(AW)) u_chk (.mclk, .reset_n, .pready,
    .prdata, .pri_req, .pri_ptr, .pri_step, .pri_mode, .pri_prog, .pri_valid, .pri_addr,
    .pri_next, .sec_req, .sec_ptr, .sec_write, .sec_byte, .sec_valid, .sec_addr);

/* tb/dp_model.sv */
/* datapath model: makes generator and stack requests.
   assumes requests are taken on the rising edge of mclk. */
`timescale 1ns/1ps
module dp_model (
    input wire logic mclk,
    output logic pri_req,
    output logic [15:0] pri_ptr,
    output logic [15:0] pri_step,
    output logic [1:0] pri_mode,
    output logic pri_prog,
    output logic sec_req,
    output logic [15:0] sec_ptr,
    output logic [15:0] sec_step,
    output logic [1:0] sec_mode,
    output logic sec_write,
    output logic sec_byte,
    output logic stack_push,
    output logic stack_pop
);
    initial begin
        {pri_req, pri_prog, sec_req, sec_write, sec_byte, stack_push, stack_pop} = '0;
        {pri_ptr, pri_step, pri_mode, sec_ptr, sec_step, sec_mode} = '0;
    end
    task automatic gen(input logic pe, input logic [15:0] pp, ps, input logic [1:0] pm,
        input logic pg, input logic se, input logic [15:0] sp, ss, input logic [1:0] sm,
        input logic sw, sb);
        @(posedge mclk);
        pri_req <= pe;
        pri_ptr <= pp;
        pri_step <= ps;
        pri_mode <= pm;
        pri_prog <= pg;
        sec_req <= se;
        sec_ptr <= sp;
        sec_step <= ss;
        sec_mode <= sm;
        sec_write <= sw;
        sec_byte <= sb;
        @(posedge mclk);
        pri_req <= 1'b0;
        sec_req <= 1'b0;
        // released pointers flip so stale values never look valid
        pri_ptr <= ~pp;
        sec_ptr <= ~sp;
        #1;
    endtask
    task automatic stk(input logic pu, po);
        @(posedge mclk);
        stack_push <= pu;
        stack_pop <= po;
        @(posedge mclk);
        stack_push <= 1'b0;
        stack_pop <= 1'b0;
        #1;
    endtask
endmodule

/* tb/test_core_address_generation.sv */
/* self-checking bench for core_address_generation.
   apb master here; dp_model makes generator and stack requests. */
`timescale 1ns/1ps
`include "core_agen_defs.vh"
module test_core_address_generation;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pri_req, pri_prog, pri_valid, sec_req, sec_write, sec_byte, sec_valid;
    logic [15:0] pri_ptr, pri_step, pri_addr, pri_next, sec_ptr, sec_step, sec_addr, sec_next, r;
    logic [1:0] pri_mode, sec_mode;
    logic stack_push, stack_pop, stack_error, irq_disabled, irq;
    int error_cnt = 0;
    int n_checks = 0;
    core_address_generation i_dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pri_req, .pri_ptr, .pri_step, .pri_mode, .pri_prog,
        .pri_valid, .pri_addr, .pri_next, .sec_req, .sec_ptr, .sec_step, .sec_mode, .sec_write,
        .sec_byte, .sec_valid, .sec_addr, .sec_next, .stack_push, .stack_pop, .stack_error,
        .irq_disabled, .irq);
    dp_model u_dp (.mclk, .pri_req, .pri_ptr, .pri_step, .pri_mode, .pri_prog, .sec_req,
        .sec_ptr, .sec_step, .sec_mode, .sec_write, .sec_byte, .stack_push, .stack_pop);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic apb(input logic w, input logic [6:0] ix, input logic [15:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {3'h0, ix, 2'h0};
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            results();
        end
        r = prdata[15:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [6:0] ix, input logic [15:0] d);
        apb(1'b1, ix, d);
    endtask
    task automatic rd(input logic [6:0] ix, input logic [15:0] x);
        apb(1'b0, ix, 16'h0000);
        chk(r, x);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`IX_STACK, 16'h0800);
        rd(`IX_CONTROL, 16'h0020);
        rd(`IX_SLIMIT, 16'h0000);
        rd(`IX_FRAME, 16'h0000);
        wr(`IX_PC_HI, 16'hffff);
        rd(`IX_PC_HI, 16'h007f);
        wr(`IX_TPAGE, 16'hffff);
        rd(`IX_TPAGE, 16'h00ff);
        wr(`IX_ACC_AU, 16'h0080);
        rd(`IX_ACC_AU, 16'hff80);
        apb(1'b0, 7'h10, 16'h0000);
        chk({r, 15'h0, e}, 32'h1);
        wr(`IX_SLIMIT, 16'hffff);
        rd(`IX_SLIMIT, 16'hfffe);
        for (int i = 0; i < 2; i++) begin
            wr(`IX_XC_START + 7'(4 * i), 16'hffff);
            rd(`IX_XC_START + 7'(4 * i), 16'hfffe);
            wr(`IX_XC_END + 7'(4 * i), 16'h0000);
            rd(`IX_XC_END + 7'(4 * i), 16'h0001);
        end
        $display("registers done");
        wr(`IX_CIRC_CTRL, 16'hc000);
        wr(`IX_XC_START, 16'h1000);
        wr(`IX_XC_END, 16'h100e);
        wr(`IX_YC_START, 16'h2000);
        wr(`IX_YC_END, 16'h2006);
        wr(`IX_EVT_MASK, 16'h0004);
        u_dp.gen(1, 16'h100e, 16'h2, `MODE_CIRC, 0, 1, 16'h2006, 16'h2, `MODE_CIRC, 0, 0);
        chk({pri_valid, sec_valid}, 2'b11);
        chk({pri_addr, pri_next}, 32'h100e1000);
        chk({sec_addr, sec_next}, 32'h20062000);
        u_dp.gen(1, 16'h1000, 16'hfffe, `MODE_CIRC, 0, 0, 16'h0, 16'h0, 0, 0, 0);
        chk(pri_next, 16'h100e);
        u_dp.gen(1, 16'h100e, 16'h2, `MODE_CIRC, 1, 0, 16'h0, 16'h0, 0, 0, 0);
        chk(pri_next, 16'h1000);
        chk(irq, 1'b1);
        rd(`IX_EVT_STAT, 16'h0004);
        repeat (2) @(posedge mclk);
        #1 chk(irq, 1'b0);
        $display("circular done");
        wr(`IX_BITREV, 16'h8008);
        u_dp.gen(1, 16'h0, 16'h2, `MODE_BITREV, 0, 1, 16'h4, 16'h2, `MODE_BITREV, 0, 0);
        chk({pri_next, sec_next}, 32'h00080006);
        u_dp.gen(1, 16'h8, 16'h2, `MODE_BITREV, 0, 0, 16'h0, 16'h0, 0, 0, 0);
        chk(pri_next, 16'h0004);
        u_dp.gen(1, 16'h8, 16'h2, `MODE_BITREV, 1, 0, 16'h0, 16'h0, 0, 0, 0);
        chk(pri_next, 16'h000a);
        u_dp.gen(1, 16'h1234, 16'h4, `MODE_LINEAR, 0, 1, 16'h3, 16'h2, `MODE_LINEAR, 0, 0);
        chk({pri_next, sec_addr}, 32'h12380002);
        u_dp.gen(0, 16'h0, 16'h0, 0, 0, 1, 16'h10, 16'h2, `MODE_LINEAR, 1, 0);
        chk(sec_valid, 1'b0);
        u_dp.gen(0, 16'h0, 16'h0, 0, 0, 1, 16'h10, 16'h2, `MODE_LINEAR, 0, 1);
        chk(sec_valid, 1'b0);
        rd(`IX_EVT_STAT, 16'h0002);
        $display("generators done");
        wr(`IX_STACK, 16'h0802);
        wr(`IX_SLIMIT, 16'h0804);
        // equal to the limit still pushes cleanly; only the next one traps
        for (int i = 0; i < 3; i++) begin
            u_dp.stk(1, 0);
            chk(stack_error, i == 2);
            if (i == 1)
                rd(`IX_STACK, 16'h0806);
        end
        wr(`IX_STACK, 16'h0802);
        for (int i = 0; i < 2; i++) begin
            u_dp.stk(0, 1);
            chk(stack_error, i == 1);
        end
        rd(`IX_EVT_STAT, 16'h0001);
        $display("stack done");
        wr(`IX_IRQ_DIS, 16'h0003);
        @(posedge mclk);
        #1 chk(irq_disabled, 1'b1);
        repeat (2) @(posedge mclk);
        #1 chk(irq_disabled, 1'b1);
        @(posedge mclk);
        #1 chk(irq_disabled, 1'b0);
        rd(`IX_IRQ_DIS, 16'h0000);
        $display("disable done");
        results();
    end
endmodule
